// ---- lsp_device_end.sv ----
// device end: status flags, loopback lanes with transmit fifo, packet sender

// ------------------------------------------------------------------
// fifo: flip-flop storage, registered full and empty
// ------------------------------------------------------------------
module lsp_fifo #(
   parameter int W = 72,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
      logic notFull;
      logic notEmpty;
   } lsp_fifo_st_t;

   lsp_fifo_st_t st;
   lsp_fifo_st_t next_st;
   logic push;
   logic pop;

   // flags are registered so that ready never depends on the far side
   always_comb begin
      next_st = st;
      push = inValid && st.notFull;
      pop = outReady && st.notEmpty;
      if (push) begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr = st.wrPtr + 1'b1;
      end
      if (pop) begin
         next_st.rdPtr = st.rdPtr + 1'b1;
      end
      next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_st.notFull = next_st.count != DEPTH[AW:0];
      next_st.notEmpty = next_st.count != '0;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.notFull <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign inReady = st.notFull;
   assign outValid = st.notEmpty;
   assign outData = st.mem[st.rdPtr];
endmodule : lsp_fifo

// ------------------------------------------------------------------
// device end
// ------------------------------------------------------------------
module lsp_device_end #(
   parameter bit MULTI_LANE = 1'b1,
   parameter bit LOOPBACK_EN = 1'b1,
   parameter int DW = MULTI_LANE ? 64 : 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   lsp_link_if.dev link,
   input wire logic [2:0] trainedLanes,
   input wire logic inPollCompliance,
   input wire logic [1:0] dlState,
   input wire logic tlpPassing,
   output logic serTxValid,
   output logic [DW-1:0] serTxData,
   output logic [DW/8-1:0] serTxKcntl,
   input wire logic serTxReady,
   input wire logic serRxValid,
   input wire logic [DW-1:0] serRxData,
   input wire logic [DW/8-1:0] serRxKcntl,
   output logic pktOutValid,
   output logic [1:0] pktOutCmd,
   output logic [2:0] pktOutPmType,
   output logic [lsp_pkg::PAYLOAD_W-1:0] pktOutPayload,
   input wire logic pktOutDone
);
   localparam int KW = DW / 8;
   localparam int FW = DW + KW;

   typedef struct packed {
      logic [2:0] widthCode;
      logic comply;
      logic dlIdle;
      logic dlInit;
      logic dlActive;
      logic dlUp;
      logic lbkReady;
      logic txValid;
      logic [DW-1:0] txData;
      logic [KW-1:0] txKcntl;
      logic rxValid;
      logic [DW-1:0] rxData;
      logic [KW-1:0] rxKcntl;
      logic pktBusy;
      logic pktWaitIdle;
      logic [1:0] pktCmd;
      logic [2:0] pmType;
      logic [lsp_pkg::PAYLOAD_W-1:0] payload;
      logic sent;
   } lsp_dev_st_t;

   lsp_dev_st_t st;
   lsp_dev_st_t next_st;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoPop;
   logic [FW-1:0] fifoOut;

   // lane count to one-hot width code
   function automatic logic [2:0] width_code(input logic [2:0] lanes);
      unique case (lanes)
         3'h1: width_code = lsp_pkg::WIDTH_X1;
         3'h2: width_code = lsp_pkg::WIDTH_X2;
         3'h4: width_code = lsp_pkg::WIDTH_X4;
         default: width_code = lsp_pkg::WIDTH_NONE;
      endcase
   endfunction : width_code

   // ----------------------------------------------------------------
   // transmit loopback buffer
   // ----------------------------------------------------------------
   lsp_fifo #(
      .W(FW),
      .DEPTH(lsp_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .inValid(link.lbkTxValid && st.lbkReady),
      .inReady(fifoInReady),
      .inData({link.lbkTxKcntl, link.lbkTxData}),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOut)
   );

   // output stage refills whenever it is empty or being taken
   assign fifoPop = LOOPBACK_EN && (!st.txValid || serTxReady);

   always_comb begin
      next_st = st;
      next_st.widthCode = width_code(trainedLanes);
      next_st.comply = inPollCompliance;
      // unknown state codes fall back to inactive, keeping one flag high
      next_st.dlInit = dlState == lsp_pkg::LINK_LAYER_INIT_FLAG;
      next_st.dlActive = dlState == lsp_pkg::LINK_LAYER_ACTIVE_FLAG;
      next_st.dlIdle = !next_st.dlInit && !next_st.dlActive;
      next_st.dlUp = next_st.dlActive && tlpPassing;

      // loopback: ready only when built in and the buffer has room;
      // ready rests one cycle after each taken word, because that word
      // may fill the buffer before its registered full flag shows it
      next_st.lbkReady = LOOPBACK_EN && fifoInReady &&
         !(link.lbkTxValid && st.lbkReady);
      if (fifoPop) begin
         next_st.txValid = fifoOutValid;
         next_st.txData = fifoOut[DW-1:0];
         next_st.txKcntl = fifoOut[FW-1:DW];
      end
      // lanes kept in place: lane n in slice n, its flags in pair n
      next_st.rxValid = LOOPBACK_EN && serRxValid;
      if (LOOPBACK_EN && serRxValid) begin
         next_st.rxData = serRxData;
         next_st.rxKcntl = serRxKcntl;
      end

      // packet sender; command 3 and repeats of a held command ignored
      next_st.sent = 1'b0;
      if (st.pktBusy) begin
         if (pktOutDone) begin
            next_st.pktBusy = 1'b0;
            next_st.pktWaitIdle = 1'b1;
            next_st.sent = 1'b1;
         end
      end else if (st.pktWaitIdle) begin
         // a command still held after sending is not a new request
         if (link.pktCmd == lsp_pkg::CMD_IDLE) begin
            next_st.pktWaitIdle = 1'b0;
         end
      end else if (link.pktCmd == lsp_pkg::CMD_POWER ||
            link.pktCmd == lsp_pkg::CMD_VENDOR) begin
         next_st.pktBusy = 1'b1;
         next_st.pktCmd = link.pktCmd;
         next_st.pmType = link.pmType;
         next_st.payload = link.vendorPayload;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.dlIdle <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs, each straight from a flip-flop
   // ----------------------------------------------------------------
   assign link.link_width_code = st.widthCode;
   assign link.pollComplianceFlag = st.comply;
   assign link.link_layer_idle_flag = st.dlIdle;
   assign link.link_layer_init_flag = st.dlInit;
   assign link.link_layer_active_flag = st.dlActive;
   assign link.link_layer_up_flag = st.dlUp;
   assign link.pktSent = st.sent;
   assign link.lbkTxReady = st.lbkReady;
   assign link.lbkRxValid = st.rxValid;
   assign link.lbkRxData = st.rxData;
   assign link.lbkRxKcntl = st.rxKcntl;
   assign serTxValid = st.txValid;
   assign serTxData = st.txData;
   assign serTxKcntl = st.txKcntl;
   assign pktOutValid = st.pktBusy;
   assign pktOutCmd = st.pktCmd;
   assign pktOutPmType = st.pmType;
   assign pktOutPayload = st.payload;
endmodule : lsp_device_end

// ---- lsp_pkg.sv ----
// constants and types shared by both ends of the link status port
//
// What this block does
// - width code: 000 none, 001/010/100 lanes
// - compliance flag high only in polling compliance
// - loopback ready permits transmit words
// - loopback ports always exist; held inactive when not built in
// - transmit control flags: two bits per lane
// - transmit data: sixteen bits per lane
// - single lane: 16-bit data, 2-bit flags
// - receive control flags in transmit lane order
// - receive data 64 or 16 bits, lane order
// - one of idle, init, active flags high
// - link up only when active and passing
// - command: 0 idle, 1 power, 2 vendor, never 3
// - power types 000, 001, 011, 100
// - sent pulse once packet actually transmitted
// - vendor packet carries 24-bit payload
package lsp_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int LANE_W = 16;
   localparam int KFLAG_W = 2;
   localparam int PAYLOAD_W = 24;
   localparam int FIFO_DEPTH = 16;
   localparam int ADDR_W = 4;

   // ----------------------------------------------------------------
   // codes
   // ----------------------------------------------------------------
   localparam logic [2:0] WIDTH_NONE = 3'h0;
   localparam logic [2:0] WIDTH_X1 = 3'h1;
   localparam logic [2:0] WIDTH_X2 = 3'h2;
   localparam logic [2:0] WIDTH_X4 = 3'h4;

   typedef enum logic [1:0] {
      CMD_IDLE = 2'h0,
      CMD_POWER = 2'h1,
      CMD_VENDOR = 2'h2,
      CMD_UNUSED = 2'h3
   } lsp_cmd_t;

   typedef enum logic [2:0] {
      PM_ENTER_L1 = 3'h0,
      PM_ENTER_L2 = 3'h1,
      PM_ASPM_L1 = 3'h3,
      PM_REQ_ACK = 3'h4
   } lsp_pm_t;

   typedef enum logic [1:0] {
      LINK_LAYER_IDLE_FLAG = 2'h0,
      LINK_LAYER_INIT_FLAG = 2'h1,
      LINK_LAYER_ACTIVE_FLAG = 2'h2
   } lsp_dl_t;

   // ----------------------------------------------------------------
   // host register map (byte addresses) and status field positions
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_PAYLOAD = 4'h4;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
   localparam int CTRL_CMD_LSB = 0;
   localparam int CTRL_PM_LSB = 2;
   localparam int ST_WIDTH_LSB = 0;
   localparam int ST_COMPLY = 3;
   localparam int ST_IDLE = 4;
   localparam int ST_INIT = 5;
   localparam int ST_ACTIVE = 6;
   localparam int ST_UP = 7;
   localparam int ST_BUSY = 8;
   localparam int ST_SENT = 9;
   localparam logic [31:0] RDATA_RESET = 32'h0;

endpackage : lsp_pkg

// ---- lsp_link_if.sv ----
// interface joining the device end and the host end of the status port
interface lsp_link_if #(
   parameter int DW = 64
);
   // status, system side
   logic [2:0] link_width_code;
   logic pollComplianceFlag;
   logic link_layer_idle_flag;
   logic link_layer_init_flag;
   logic link_layer_active_flag;
   logic link_layer_up_flag;
   // link-layer packet command
   logic [1:0] pktCmd;
   logic [2:0] pmType;
   logic [lsp_pkg::PAYLOAD_W-1:0] vendorPayload;
   logic pktSent;
   // master loopback
   logic lbkTxReady;
   logic lbkTxValid;
   logic [DW-1:0] lbkTxData;
   logic [DW/8-1:0] lbkTxKcntl;
   logic lbkRxValid;
   logic [DW-1:0] lbkRxData;
   logic [DW/8-1:0] lbkRxKcntl;

   modport dev (
      output link_width_code, pollComplianceFlag, link_layer_idle_flag,
      output link_layer_init_flag, link_layer_active_flag,
      output link_layer_up_flag, pktSent, lbkTxReady,
      output lbkRxValid, lbkRxData, lbkRxKcntl,
      input pktCmd, pmType, vendorPayload,
      input lbkTxValid, lbkTxData, lbkTxKcntl
   );

   modport host (
      input link_width_code, pollComplianceFlag, link_layer_idle_flag,
      input link_layer_init_flag, link_layer_active_flag,
      input link_layer_up_flag, pktSent, lbkTxReady,
      input lbkRxValid, lbkRxData, lbkRxKcntl,
      output pktCmd, pmType, vendorPayload,
      output lbkTxValid, lbkTxData, lbkTxKcntl
   );
endinterface : lsp_link_if

// ---- lsp_host_end.sv ----
// host end: register port for status and packet commands, loopback streams
module lsp_host_end #(
   parameter bit MULTI_LANE = 1'b1,
   parameter int DW = MULTI_LANE ? 64 : 16
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   lsp_link_if.host link,
   input wire logic [lsp_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic srcValid,
   input wire logic [DW-1:0] srcData,
   input wire logic [DW/8-1:0] srcKcntl,
   output logic srcReady,
   output logic sinkValid,
   output logic [DW-1:0] sinkData,
   output logic [DW/8-1:0] sinkKcntl
);
   localparam int KW = DW / 8;

   typedef enum logic [0:0] {
      HS_IDLE = 1'b0,
      HS_WAIT = 1'b1
   } lsp_host_state_t;

   typedef struct packed {
      lsp_host_state_t state;
      logic [1:0] cmd;
      logic [2:0] pmType;
      logic [lsp_pkg::PAYLOAD_W-1:0] payload;
      logic sentSticky;
      logic [31:0] rdata;
      logic txValid;
      logic [DW-1:0] txData;
      logic [KW-1:0] txKcntl;
      logic srcReady;
      logic sinkValid;
      logic [DW-1:0] sinkData;
      logic [KW-1:0] sinkKcntl;
   } lsp_host_st_t;

   lsp_host_st_t st;
   lsp_host_st_t next_st;
   logic [31:0] status;
   logic [1:0] wrCmd;
   logic txTaken;
   logic txLoad;

   // status word seen by software
   always_comb begin
      status = '0;
      status[lsp_pkg::ST_WIDTH_LSB +: 3] = link.link_width_code;
      status[lsp_pkg::ST_COMPLY] = link.pollComplianceFlag;
      status[lsp_pkg::ST_IDLE] = link.link_layer_idle_flag;
      status[lsp_pkg::ST_INIT] = link.link_layer_init_flag;
      status[lsp_pkg::ST_ACTIVE] = link.link_layer_active_flag;
      status[lsp_pkg::ST_UP] = link.link_layer_up_flag;
      status[lsp_pkg::ST_BUSY] = st.state == HS_WAIT;
      status[lsp_pkg::ST_SENT] = st.sentSticky;
   end

   assign wrCmd = regWdata[lsp_pkg::CTRL_CMD_LSB +: 2];
   // a word sent to the device leaves when the device is ready for it
   assign txTaken = st.txValid && link.lbkTxReady;
   assign txLoad = srcValid && st.srcReady;

   always_comb begin
      next_st = st;

      // register reads answer one cycle later; unmapped reads give zero
      if (regRd) begin
         unique case (regAddr)
            lsp_pkg::REG_CTRL: next_st.rdata =
               {27'h0, st.pmType, st.cmd};
            lsp_pkg::REG_PAYLOAD: next_st.rdata = {8'h0, st.payload};
            lsp_pkg::REG_STATUS: next_st.rdata = status;
            default: next_st.rdata = lsp_pkg::RDATA_RESET;
         endcase
      end else begin
         next_st.rdata = lsp_pkg::RDATA_RESET;
      end

      if (regWr && regAddr == lsp_pkg::REG_PAYLOAD) begin
         next_st.payload = regWdata[lsp_pkg::PAYLOAD_W-1:0];
      end
      // write one to clear; a sent pulse in the same cycle wins
      if (regWr && regAddr == lsp_pkg::REG_STATUS &&
            regWdata[lsp_pkg::ST_SENT]) begin
         next_st.sentSticky = 1'b0;
      end

      unique case (st.state)
         HS_IDLE: begin
            // code 3 is refused here so it never reaches the link
            if (regWr && regAddr == lsp_pkg::REG_CTRL &&
                  (wrCmd == lsp_pkg::CMD_POWER ||
                  wrCmd == lsp_pkg::CMD_VENDOR)) begin
               next_st.cmd = wrCmd;
               next_st.pmType = regWdata[lsp_pkg::CTRL_PM_LSB +: 3];
               next_st.state = HS_WAIT;
            end
         end
         HS_WAIT: begin
            // command and type frozen until sent comes back; payload writes still land
            if (link.pktSent) begin
               next_st.cmd = lsp_pkg::CMD_IDLE;
               next_st.state = HS_IDLE;
            end
         end
      endcase
      if (link.pktSent) begin
         next_st.sentSticky = 1'b1;
      end

      // one-word holding stage toward the device
      if (txTaken) begin
         next_st.txValid = 1'b0;
      end
      if (txLoad) begin
         next_st.txValid = 1'b1;
         next_st.txData = srcData;
         next_st.txKcntl = srcKcntl;
      end
      // full throughput trades for one idle cycle after each word
      next_st.srcReady = !next_st.txValid;

      // received words pass through in device lane order
      next_st.sinkValid = link.lbkRxValid;
      if (link.lbkRxValid) begin
         next_st.sinkData = link.lbkRxData;
         next_st.sinkKcntl = link.lbkRxKcntl;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
         st.srcReady <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign link.pktCmd = st.cmd;
   assign link.pmType = st.pmType;
   assign link.vendorPayload = st.payload;
   assign link.lbkTxValid = st.txValid;
   assign link.lbkTxData = st.txData;
   assign link.lbkTxKcntl = st.txKcntl;
   assign regRdata = st.rdata;
   assign srcReady = st.srcReady;
   assign sinkValid = st.sinkValid;
   assign sinkData = st.sinkData;
   assign sinkKcntl = st.sinkKcntl;
endmodule : lsp_host_end

// ---- lsp_link_properties.sv ----
// concurrent checks on the link between the device end and the host end
module lsp_link_properties #(
   parameter int DW = 64
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] link_width_code,
   input wire logic link_layer_idle_flag,
   input wire logic link_layer_init_flag,
   input wire logic link_layer_active_flag,
   input wire logic link_layer_up_flag,
   input wire logic [1:0] pktCmd,
   input wire logic [2:0] pmType,
   input wire logic [lsp_pkg::PAYLOAD_W-1:0] vendorPayload,
   input wire logic pktSent,
   input wire logic lbkTxReady,
   input wire logic lbkTxValid,
   input wire logic [DW-1:0] lbkTxData,
   input wire logic lbkRxValid
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   // one clock domain, so clock and reset are stated once
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   property p_widthCode;
      link_width_code inside {3'h0, 3'h1, 3'h2, 3'h4};
   endproperty
   a_widthCode: assert property (p_widthCode)
      else $error("width code not one-hot or zero");

   property p_dlOneHot;
      $onehot({link_layer_idle_flag, link_layer_init_flag,
               link_layer_active_flag});
   endproperty
   a_dlOneHot: assert property (p_dlOneHot)
      else $error("link layer state flags not one-hot");

   property p_upNeedsActive;
      link_layer_up_flag |-> link_layer_active_flag;
   endproperty
   a_upNeedsActive: assert property (p_upNeedsActive)
      else $error("link up without active state");

   property p_noCmd3;
      pktCmd != 2'h3;
   endproperty
   a_noCmd3: assert property (p_noCmd3)
      else $error("packet command 3 driven");

   // a changing command would make the sender transmit a mix of two
   property p_cmdHold;
      (pktCmd != 2'h0 && !pktSent) |=>
         ($stable(pktCmd) && $stable(pmType) && $stable(vendorPayload));
   endproperty
   a_cmdHold: assert property (p_cmdHold)
      else $error("packet command changed before sent");

   property p_sentIdle;
      pktSent |=> (pktCmd == 2'h0 && !pktSent);
   endproperty
   a_sentIdle: assert property (p_sentIdle)
      else $error("sent not a pulse or command not idled");

   property p_sentHasCmd;
      pktSent |-> pktCmd != 2'h0;
   endproperty
   a_sentHasCmd: assert property (p_sentHasCmd)
      else $error("sent without a pending command");

   property p_txHold;
      (lbkTxValid && !lbkTxReady) |=> (lbkTxValid && $stable(lbkTxData));
   endproperty
   a_txHold: assert property (p_txHold)
      else $error("loopback word dropped while not ready");

   c_sent: cover property (pktSent);
   c_txFull: cover property (lbkTxValid && !lbkTxReady);
   c_rx: cover property (lbkRxValid);
   c_up: cover property (link_layer_up_flag);
endmodule : lsp_link_properties

// ---- tb.sv ----
// self-checking bench joining the device end and the host end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] trainedLanes = 3'h0;
   logic inPollCompliance = 1'b0;
   logic [1:0] dlState = 2'h0;
   logic tlpPassing = 1'b0;
   logic serTxValid;
   logic [63:0] serTxData;
   logic [7:0] serTxKcntl;
   logic serTxReady = 1'b0;
   logic serRxValid = 1'b0;
   logic [63:0] serRxData = 64'h0;
   logic [7:0] serRxKcntl = 8'h0;
   logic pktOutValid;
   logic [1:0] pktOutCmd;
   logic [2:0] pktOutPmType;
   logic [23:0] pktOutPayload;
   logic pktOutDone = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic srcValid = 1'b0;
   logic [63:0] srcData = 64'h0;
   logic [7:0] srcKcntl = 8'h0;
   logic srcReady;
   logic sinkValid;
   logic [63:0] sinkData;
   logic [7:0] sinkKcntl;
   int errTotal = 0;
   int nChecks = 0;
   logic [71:0] txq[$];
   logic [71:0] rxq[$];

   always #12.5 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // both ends and the checker
   // ----------------------------------------------------------------
   lsp_link_if #(.DW(64)) link ();
   lsp_device_end #(.MULTI_LANE(1'b1), .LOOPBACK_EN(1'b1))
   u_lsp_device_end (.clk_sys(clk_sys), .rst_b(rst_b), .link(link.dev),
      .trainedLanes(trainedLanes), .inPollCompliance(inPollCompliance),
      .dlState(dlState), .tlpPassing(tlpPassing), .serTxValid(serTxValid),
      .serTxData(serTxData), .serTxKcntl(serTxKcntl),
      .serTxReady(serTxReady), .serRxValid(serRxValid),
      .serRxData(serRxData), .serRxKcntl(serRxKcntl),
      .pktOutValid(pktOutValid), .pktOutCmd(pktOutCmd),
      .pktOutPmType(pktOutPmType), .pktOutPayload(pktOutPayload),
      .pktOutDone(pktOutDone));
   lsp_host_end #(.MULTI_LANE(1'b1)) u_lsp_host_end (
      .clk_sys(clk_sys), .rst_b(rst_b), .link(link.host),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .srcValid(srcValid),
      .srcData(srcData), .srcKcntl(srcKcntl), .srcReady(srcReady),
      .sinkValid(sinkValid), .sinkData(sinkData), .sinkKcntl(sinkKcntl));
   lsp_link_properties #(.DW(64)) u_lsp_link_properties (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .link_width_code(link.link_width_code),
      .link_layer_idle_flag(link.link_layer_idle_flag),
      .link_layer_init_flag(link.link_layer_init_flag),
      .link_layer_active_flag(link.link_layer_active_flag),
      .link_layer_up_flag(link.link_layer_up_flag),
      .pktCmd(link.pktCmd), .pmType(link.pmType),
      .vendorPayload(link.vendorPayload), .pktSent(link.pktSent),
      .lbkTxReady(link.lbkTxReady), .lbkTxValid(link.lbkTxValid),
      .lbkTxData(link.lbkTxData), .lbkRxValid(link.lbkRxValid));

   // ----------------------------------------------------------------
   // compares, bus cycles, helpers
   // ----------------------------------------------------------------
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkReg

   task automatic chkWord(input logic [71:0] got, input logic [71:0] exp);
      nChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkWord

   // every bus task starts and ends just after a rising edge
   task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(posedge clk_sys);
   endtask : regWrite

   task automatic regRead(input logic [3:0] a, output logic [31:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 d = regRdata;
      @(posedge clk_sys);
   endtask : regRead

   // lane slices differ so a swapped lane shows up
   function automatic logic [71:0] mkWord(input int n);
      return {16'h3000 + 16'(n), 16'h2000 + 16'(n), 16'h1000 + 16'(n),
              16'(n), 8'(n * 5)};
   endfunction : mkWord

   function automatic logic [31:0] expStatus(input logic [2:0] ln,
      input logic pc, input logic [1:0] dl, input logic tp);
      logic [31:0] st;
      st = 32'h0;
      st[2:0] = (ln == 3'h1 || ln == 3'h2 || ln == 3'h4) ? ln : 3'h0;
      st[lsp_pkg::ST_COMPLY] = pc;
      st[lsp_pkg::ST_IDLE] = (dl == 2'h0 || dl == 2'h3);
      st[lsp_pkg::ST_INIT] = (dl == 2'h1);
      st[lsp_pkg::ST_ACTIVE] = (dl == 2'h2);
      st[lsp_pkg::ST_UP] = (dl == 2'h2) && tp;
      return st;
   endfunction : expStatus

   // one packet, with a refused second order while the first is pending
   task automatic sendPkt(input logic [1:0] cmd, input logic [2:0] pm,
      input logic [23:0] pay);
      logic [31:0] d;
      regWrite(lsp_pkg::REG_PAYLOAD, 32'(pay));
      regWrite(lsp_pkg::REG_CTRL, 32'({pm, cmd}));
      for (int k = 0; k < 20 && pktOutValid !== 1'b1; k++) @(posedge clk_sys);
      #1;
      if (cmd == 2'h1) chkReg(32'({pktOutValid, pktOutCmd, pktOutPmType}),
         32'({1'b1, cmd, pm}));
      else chkReg(32'({pktOutValid, pktOutCmd, pktOutPayload}),
         32'({1'b1, cmd, pay}));
      @(posedge clk_sys);
      regWrite(lsp_pkg::REG_CTRL, 32'h2);
      pktOutDone <= 1'b1;
      @(posedge clk_sys);
      pktOutDone <= 1'b0;
      repeat (3) @(posedge clk_sys);
      regRead(lsp_pkg::REG_STATUS, d);
      chkReg(d & 32'h300, 32'h200);
      regWrite(lsp_pkg::REG_STATUS, 32'h200);
      regRead(lsp_pkg::REG_STATUS, d);
      chkReg({d[9], pktOutValid}, 32'h0);
   endtask : sendPkt

   task automatic wrapUp();
      $display("checks=%0d mismatches=%0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrapUp

   // words leaving the sink must match the received order; looked at
   // mid-cycle so the launching edge never races the compare
   always @(negedge clk_sys) begin
      if (rst_b && sinkValid === 1'b1)
         chkWord({sinkData, sinkKcntl},
            rxq.size() > 0 ? rxq.pop_front() : 'x);
   end

   // about 220 cycles of tests; far longer means a hang
   initial begin
      #(25ns * 20000);
      errTotal++;
      wrapUp();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      int k;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chkReg(32'(link.lbkTxReady), 32'h1);
      // status table: every width input, compliance, state and passing
      for (int i = 0; i < 8; i++) begin
         trainedLanes <= 3'(i);
         inPollCompliance <= i[0];
         dlState <= 2'(i);
         tlpPassing <= i[2];
         repeat (2) @(posedge clk_sys);
         regRead(lsp_pkg::REG_STATUS, d);
         chkReg(d, expStatus(3'(i), i[0], 2'(i), i[2]));
      end
      sendPkt(2'h1, 3'h0, 24'h0);
      sendPkt(2'h1, 3'h1, 24'h0);
      sendPkt(2'h1, 3'h3, 24'h0);
      sendPkt(2'h1, 3'h4, 24'h0);
      sendPkt(2'h2, 3'h0, 24'hA5C3E1);
      regWrite(lsp_pkg::REG_CTRL, 32'h3);
      repeat (4) @(posedge clk_sys);
      chkReg(32'(pktOutValid), 32'h0);
      regRead(4'hC, d);
      chkReg(d, 32'h0);
      // fill the transmit path with the lanes stalled
      for (int n = 0; n < 24; n++) begin
         srcValid <= 1'b1;
         {srcData, srcKcntl} <= mkWord(n);
         #1;
         for (k = 0; k < 12 && srcReady !== 1'b1; k++) @(posedge clk_sys) #1;
         @(posedge clk_sys);
         if (k == 12) break;
         txq.push_back(mkWord(n));
      end
      srcValid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      // buffer keeps FIFO_DEPTH words, output stage and host holding stage one each
      chkReg({link.lbkTxReady, txq.size() == lsp_pkg::FIFO_DEPTH + 2},
         32'h1);
      // drain with the lanes stalling every fourth cycle
      for (k = 0; k < 200 && txq.size() > 0; k++) begin
         serTxReady <= (k % 4 != 1);
         #1;
         if (serTxValid === 1'b1 && serTxReady)
            chkWord({serTxData, serTxKcntl}, txq.pop_front());
         @(posedge clk_sys);
      end
      chkReg({txq.size() == 0, link.lbkTxReady}, 32'h3);
      // received words back to back
      for (int n = 0; n < 4; n++) begin
         serRxValid <= 1'b1;
         {serRxData, serRxKcntl} <= mkWord(n + 40);
         rxq.push_back(mkWord(n + 40));
         @(posedge clk_sys);
      end
      serRxValid <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chkReg(32'(rxq.size()), 32'h0);
      wrapUp();
   end
endmodule : tb
